// *** ee_link_consts.svh ***
// constants for the two-wire memory link, both ends
// assumes inclusion by bare name before any module that uses it
`ifndef EE_LINK_CONSTS_SVH
`define EE_LINK_CONSTS_SVH
`define EE_DEV_TYPE 4'h5 // device type code, arbitrary value
`define EE_WR_TIME_US 5000 // internal write time in microseconds
`define EE_CLK_MHZ 100 // reference clock rate
`define EE_BYTE_BITS 4'h8 // data bits per byte frame
`define EE_ACK_SLOT 4'h9 // count after the ninth rising edge
`define EE_SCL_QTR 3'h4 // last tick of one quarter of a bus bit
`define EE_QTR_LAST 2'h3 // last quarter of a bit
`define EE_BUSY_W 20 // width of the write timer
`define EE_MEM_DEPTH 256 // memory bytes
`endif

// *** ee_link_pkg.sv ***
// types shared by the two ends of the two-wire memory link
// assumes nothing beyond a SystemVerilog compiler
package ee_link_pkg;
  // device protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, // standby, waits for start
    ST_DEVADDR = 3'h1, // receives slave address
    ST_WORDADDR = 3'h2, // receives word address
    ST_WDATA = 3'h3, // receives write data
    ST_RDATA = 3'h4, // transmits read data
    ST_BUSY = 3'h5 // internal write, deaf to the bus
  } slave_state_t;
  // master sequencer states
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_START = 2'h1, H_BYTE = 2'h2, H_STOP = 2'h3
  } host_state_t;
  // byte kinds the master sends or receives
  typedef enum logic [2:0] {
    SEG_SW = 3'h0, SEG_WA = 3'h1, SEG_WD = 3'h2, SEG_SR = 3'h3, SEG_RX = 3'h4
  } seg_t;
endpackage : ee_link_pkg

// *** ee_two_wire_if.sv ***
// two-wire bus between master and memory slave
// assumes open-drain data resolved here with a pull-up, clock driven by master
`timescale 1ns/10ps
interface ee_two_wire_if;
  logic scl; // serial clock from the master
  logic m_sda_o; // master data out, always low
  logic m_sda_oe_n; // master pulls data low when zero
  logic s_sda_o; // slave data out, always low
  logic s_sda_oe_n; // slave pulls data low when zero
  logic sda; // resolved data line
  // wired-and with pull-up
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);
  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe_n);
endinterface : ee_two_wire_if

// *** ee_slave.sv ***
// memory slave end of the two-wire link: 256 bytes, 4-byte page write
// assumes the master drives scl and an external pull-up on sda
// Contract
// [RL1] data changes only while clock low
// [RL2] start is data fall, clock high
// [RL3] stop is data rise, clock high
// [RL4] stop after read returns to standby
// [RL5] master stops only after line released
// [RL6] ninth clock: receiver pulls data low
// [RL7] acknowledge only a matching slave address
// [RL8] write selected: acknowledge every further byte
// [RL9] read: eight bits, then sample acknowledge
// [RL10] no acknowledge ends read; master stops
// [RL11] upper four address bits match type
// [RL12] next three address bits are reserved
// [RL13] lowest address bit: one read, zero write
// [RL14] write: word address, then one data byte
// [RL15] stop after write starts internal write
// [RL16] busy device ignores every request
// [RL17] internal write lasts five milliseconds
// [RL18] master starts transfers, clocks both directions
// [RL19] up to four bytes, low bits wrap
// [RL20] no acknowledge while internal write runs
// [RL21] address counter increments, wraps at 255
// [RL22] lines synchronised and filtered before use
// [RL23] data output only pulls low
`timescale 1ns/10ps
`include "ee_link_consts.svh"
module ee_slave #(
  parameter int WRITE_CYCLES = `EE_WR_TIME_US * `EE_CLK_MHZ, // internal write length
  parameter logic [3:0] DEV_TYPE = `EE_DEV_TYPE // device type, arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ee_two_wire_if.slave link,
  output logic o_busy,
  output logic o_standby
);
  localparam logic [`EE_BUSY_W-1:0] BUSY_LAST = `EE_BUSY_W'(WRITE_CYCLES - 1);

  // line pipeline, bit 0 scl, bit 1 sda
  logic [1:0] sync0_reg, sync0_next; // first stage, read only by stage two
  logic [1:0] sync1_reg, sync1_next; // second stage
  logic [1:0] hist_reg, hist_next; // previous synchronised sample
  logic [1:0] flt_reg, flt_next; // filtered line levels
  logic [1:0] old_reg, old_next; // filtered levels one cycle back
  logic scl_rise, scl_fall, start_det, stop_det;

  // protocol state
  ee_link_pkg::slave_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next; // rising edges in the frame
  logic [7:0] shift_reg, shift_next; // receive or transmit byte
  logic [7:0] addr_reg, addr_next; // address counter
  logic oe_n_reg, oe_n_next; // sda pull-down, low drives
  logic mack_reg, mack_next; // master acknowledged last byte
  logic [7:0] pg_data_reg [4]; // page buffer
  logic [7:0] pg_data_next [4];
  logic [3:0] pg_valid_reg, pg_valid_next; // page bytes received
  logic [`EE_BUSY_W-1:0] busy_cnt_reg, busy_cnt_next; // write timer
  logic busy_reg, busy_next;
  logic standby_reg, standby_next;

  // memory write port
  logic [7:0] mem_reg [`EE_MEM_DEPTH]; // storage array
  logic mem_we;
  logic [7:0] mem_waddr, mem_wdata, mem_rdata;

  // synchroniser and glitch filter: new level only after two equal samples
  always_comb begin
    sync0_next = {link.sda, link.scl};
    sync1_next = sync0_reg;
    hist_next = sync1_reg;
    old_next = flt_reg;
    for (int i = 0; i < 2; i++) begin
      flt_next[i] = (sync1_reg[i] == hist_reg[i]) ? sync1_reg[i] : flt_reg[i]; // [RL22]
    end
  end

  // line pipeline registers, bus idles high
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sync0_reg <= 2'h3;
      sync1_reg <= 2'h3;
      hist_reg <= 2'h3;
      flt_reg <= 2'h3;
      old_reg <= 2'h3;
    end else begin
      sync0_reg <= sync0_next;
      sync1_reg <= sync1_next;
      hist_reg <= hist_next;
      flt_reg <= flt_next;
      old_reg <= old_next;
    end
  end

  // bus events; sda moving under high scl is start or stop only
  assign scl_rise = flt_reg[0] & ~old_reg[0];
  assign scl_fall = ~flt_reg[0] & old_reg[0];
  assign start_det = flt_reg[0] & old_reg[0] & old_reg[1] & ~flt_reg[1]; // [RL1] [RL2]
  assign stop_det = flt_reg[0] & old_reg[0] & ~old_reg[1] & flt_reg[1]; // [RL1] [RL3]

  assign mem_rdata = mem_reg[addr_reg];

  // protocol engine
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    oe_n_next = oe_n_reg;
    mack_next = mack_reg;
    pg_data_next = pg_data_reg;
    pg_valid_next = pg_valid_reg;
    busy_cnt_next = busy_cnt_reg;
    mem_we = 1'b0;
    mem_waddr = {addr_reg[7:2], busy_cnt_reg[1:0]};
    mem_wdata = pg_data_reg[busy_cnt_reg[1:0]];
    if (state_reg == ee_link_pkg::ST_BUSY) begin
      // inputs disabled, no start or address is seen [RL16] [RL20]
      busy_cnt_next = busy_cnt_reg + 1'b1;
      // commit one page byte per cycle at the start of the cycle
      if (busy_cnt_reg[`EE_BUSY_W-1:2] == '0) begin
        mem_we = pg_valid_reg[busy_cnt_reg[1:0]]; // [RL15]
      end
      if (busy_cnt_reg == BUSY_LAST) begin // [RL17]
        state_next = ee_link_pkg::ST_IDLE;
        pg_valid_next = 4'h0;
      end
    end else if (start_det) begin
      // start from any state but busy, also a repeated start
      state_next = ee_link_pkg::ST_DEVADDR; // [RL2] [RL11]
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
      pg_valid_next = 4'h0;
    end else if (stop_det) begin
      oe_n_next = 1'b1;
      cnt_next = 4'h0;
      if (state_reg == ee_link_pkg::ST_WDATA && pg_valid_reg != 4'h0) begin
        state_next = ee_link_pkg::ST_BUSY; // [RL15]
        busy_cnt_next = '0;
      end else begin
        state_next = ee_link_pkg::ST_IDLE; // [RL3] [RL4]
      end
    end else if (state_reg != ee_link_pkg::ST_IDLE) begin
      if (scl_rise) begin
        if (cnt_reg < `EE_BYTE_BITS) begin
          cnt_next = cnt_reg + 4'h1;
          // receivers shift msb first on each rising edge
          if (state_reg != ee_link_pkg::ST_RDATA) begin
            shift_next = {shift_reg[6:0], flt_reg[1]};
          end
        end else begin
          cnt_next = `EE_ACK_SLOT;
          mack_next = ~flt_reg[1]; // [RL9]
        end
      end else if (scl_fall) begin
        if (cnt_reg == `EE_BYTE_BITS) begin
          // eight bits done: release, then acknowledge if receiving [RL6]
          oe_n_next = 1'b1;
          case (state_reg)
            ee_link_pkg::ST_DEVADDR: begin
              // reserved bits 3..1 take no part in the match [RL12]
              if (shift_reg[7:4] == DEV_TYPE) begin
                oe_n_next = 1'b0; // [RL7] [RL11]
              end else begin
                state_next = ee_link_pkg::ST_IDLE; // [RL7]
              end
            end
            ee_link_pkg::ST_WORDADDR: begin
              addr_next = shift_reg; // [RL14]
              oe_n_next = 1'b0; // [RL8]
            end
            ee_link_pkg::ST_WDATA: begin
              // page byte stored, only low address bits advance
              pg_data_next[addr_reg[1:0]] = shift_reg; // [RL19]
              pg_valid_next[addr_reg[1:0]] = 1'b1;
              addr_next = {addr_reg[7:2], addr_reg[1:0] + 2'h1}; // [RL19]
              oe_n_next = 1'b0; // [RL8] [RL14]
            end
            default: begin
              oe_n_next = 1'b1; // read: free the line for the master [RL9]
            end
          endcase
        end else if (cnt_reg == `EE_ACK_SLOT) begin
          // ninth clock over: release and pick next action
          oe_n_next = 1'b1;
          cnt_next = 4'h0;
          case (state_reg)
            ee_link_pkg::ST_DEVADDR: begin
              if (shift_reg[0]) begin // [RL13]
                state_next = ee_link_pkg::ST_RDATA;
                shift_next = mem_rdata;
                oe_n_next = mem_rdata[7];
                addr_next = addr_reg + 8'h1; // [RL21]
              end else begin
                state_next = ee_link_pkg::ST_WORDADDR; // [RL13]
              end
            end
            ee_link_pkg::ST_WORDADDR: begin
              state_next = ee_link_pkg::ST_WDATA; // [RL14]
            end
            ee_link_pkg::ST_RDATA: begin
              if (mack_reg) begin // [RL9]
                shift_next = mem_rdata;
                oe_n_next = mem_rdata[7];
                addr_next = addr_reg + 8'h1; // [RL21]
              end else begin
                state_next = ee_link_pkg::ST_IDLE; // [RL10]
              end
            end
            default: begin
              state_next = state_reg;
            end
          endcase
        end else if (state_reg == ee_link_pkg::ST_RDATA && cnt_reg != 4'h0) begin
          // next bit goes out while scl is low [RL1]
          shift_next = {shift_reg[6:0], 1'b0};
          oe_n_next = shift_reg[6]; // [RL23]
        end
      end
    end
    busy_next = (state_next == ee_link_pkg::ST_BUSY);
    standby_next = (state_next == ee_link_pkg::ST_IDLE); // [RL4]
  end

  // protocol registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_reg <= ee_link_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h0;
      addr_reg <= 8'h0;
      oe_n_reg <= 1'b1;
      mack_reg <= 1'b0;
      pg_data_reg <= '{default: 8'h0};
      pg_valid_reg <= 4'h0;
      busy_cnt_reg <= '0;
      busy_reg <= 1'b0;
      standby_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      oe_n_reg <= oe_n_next;
      mack_reg <= mack_next;
      pg_data_reg <= pg_data_next;
      pg_valid_reg <= pg_valid_next;
      busy_cnt_reg <= busy_cnt_next;
      busy_reg <= busy_next;
      standby_reg <= standby_next;
    end
  end

  // storage, no reset on contents
  always_ff @(posedge i_ref_clk) begin
    if (mem_we) begin
      mem_reg[mem_waddr] <= mem_wdata;
    end
  end

  // open drain: output value fixed low, only the enable moves [RL23]
  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe_n = oe_n_reg;
  assign o_busy = busy_reg;
  assign o_standby = standby_reg;
endmodule : ee_slave

// *** ee_master.sv ***
// master end of the two-wire memory link: byte write and single-byte reads
// assumes a slave with pull-up on sda; this end makes scl by dividing the clock
`timescale 1ns/10ps
`include "ee_link_consts.svh"
module ee_master (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ee_two_wire_if.master link,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_rd,
  input wire logic i_cmd_rand,
  input wire logic [6:0] i_slave_addr,
  input wire logic [7:0] i_word_addr,
  input wire logic [7:0] i_wdata,
  output logic o_cmd_ready,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata
);
  ee_link_pkg::host_state_t state_reg, state_next;
  ee_link_pkg::seg_t seg_reg, seg_next; // byte in progress
  logic [2:0] tick_reg, tick_next; // cycles within a quarter
  logic [1:0] q_reg, q_next; // quarter of the bit
  logic [3:0] bit_reg, bit_next; // bit of the frame, 8 is acknowledge
  logic [7:0] tx_reg, tx_next;
  logic [7:0] rx_reg, rx_next;
  logic scl_reg, scl_next;
  logic oe_n_reg, oe_n_next; // sda pull-down, low drives
  logic rd_reg, rd_next, rand_reg, rand_next;
  logic [6:0] saddr_reg, saddr_next;
  logic [7:0] waddr_reg, waddr_next, wdata_reg, wdata_next;
  logic nack_reg, nack_next, done_reg, done_next, ready_reg, ready_next;
  logic [1:0] sda_sync_reg, sda_sync_next; // stage 0 read only by stage 1
  logic step;

  // byte sent for each kind; receive leaves the line free
  function automatic logic [7:0] seg_byte(input ee_link_pkg::seg_t s, input logic [6:0] sa,
                                          input logic [7:0] wa, input logic [7:0] wd);
    case (s)
      ee_link_pkg::SEG_SW: seg_byte = {sa, 1'b0};
      ee_link_pkg::SEG_SR: seg_byte = {sa, 1'b1};
      ee_link_pkg::SEG_WA: seg_byte = wa;
      ee_link_pkg::SEG_WD: seg_byte = wd;
      default: seg_byte = 8'hff;
    endcase
  endfunction : seg_byte

  assign step = (tick_reg == `EE_SCL_QTR);

  // sequencer: each bit is four quarters, sda moves mid-low
  always_comb begin
    state_next = state_reg;
    seg_next = seg_reg;
    tick_next = step ? 3'h0 : tick_reg + 3'h1;
    q_next = q_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    scl_next = scl_reg;
    oe_n_next = oe_n_reg;
    rd_next = rd_reg;
    rand_next = rand_reg;
    saddr_next = saddr_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    nack_next = nack_reg;
    done_next = 1'b0;
    ready_next = ready_reg;
    sda_sync_next = {sda_sync_reg[0], link.sda};
    case (state_reg)
      ee_link_pkg::H_IDLE: begin
        tick_next = 3'h0;
        if (i_cmd_valid && ready_reg) begin
          // every transfer opens here [RL18]
          rd_next = i_cmd_rd;
          rand_next = i_cmd_rand;
          saddr_next = i_slave_addr;
          waddr_next = i_word_addr;
          wdata_next = i_wdata;
          seg_next = (i_cmd_rd && !i_cmd_rand) ? ee_link_pkg::SEG_SR : ee_link_pkg::SEG_SW;
          nack_next = 1'b0;
          ready_next = 1'b0;
          q_next = 2'h0;
          state_next = ee_link_pkg::H_START;
        end
      end
      ee_link_pkg::H_START: begin
        if (step) begin
          q_next = q_reg + 2'h1;
          case (q_reg)
            2'h0: oe_n_next = 1'b1;
            2'h1: scl_next = 1'b1;
            2'h2: oe_n_next = 1'b0; // [RL2]
            default: begin
              scl_next = 1'b0;
              bit_next = 4'h0;
              tx_next = seg_byte(seg_reg, saddr_reg, waddr_reg, wdata_reg); // [RL11]
              state_next = ee_link_pkg::H_BYTE;
            end
          endcase
        end
      end
      ee_link_pkg::H_BYTE: begin
        if (step) begin
          q_next = q_reg + 2'h1;
          case (q_reg)
            2'h0: begin
              // tx bits drive, receive and acknowledge slot release [RL1] [RL6]
              if (bit_reg < `EE_BYTE_BITS && seg_reg != ee_link_pkg::SEG_RX) begin
                oe_n_next = tx_reg[7];
              end else begin
                oe_n_next = 1'b1; // single read byte never acknowledged [RL10]
              end
            end
            2'h1: scl_next = 1'b1;
            2'h2: begin
              if (bit_reg < `EE_BYTE_BITS) begin
                rx_next = {rx_reg[6:0], sda_sync_reg[1]};
              end else if (seg_reg != ee_link_pkg::SEG_RX && sda_sync_reg[1]) begin
                nack_next = 1'b1; // slave gave no acknowledge [RL7] [RL20]
              end
            end
            default: begin
              scl_next = 1'b0;
              tx_next = {tx_reg[6:0], 1'b1};
              bit_next = bit_reg + 4'h1;
              if (bit_reg == `EE_BYTE_BITS) begin
                state_next = ee_link_pkg::H_STOP;
                if (!nack_reg) begin
                  case (seg_reg)
                    ee_link_pkg::SEG_SW: begin
                      seg_next = ee_link_pkg::SEG_WA;
                      state_next = ee_link_pkg::H_BYTE;
                    end
                    ee_link_pkg::SEG_WA: begin
                      seg_next = rd_reg ? ee_link_pkg::SEG_SR : ee_link_pkg::SEG_WD;
                      state_next = rd_reg ? ee_link_pkg::H_START : ee_link_pkg::H_BYTE;
                    end
                    ee_link_pkg::SEG_SR: begin
                      seg_next = ee_link_pkg::SEG_RX;
                      state_next = ee_link_pkg::H_BYTE;
                    end
                    default: state_next = ee_link_pkg::H_STOP; // [RL14]
                  endcase
                end
                bit_next = 4'h0;
                tx_next = seg_byte(seg_next, saddr_reg, waddr_reg, wdata_reg);
              end
            end
          endcase
        end
      end
      default: begin
        // stop: low while scl low, then rise under high scl [RL3] [RL5]
        if (step) begin
          q_next = q_reg + 2'h1;
          case (q_reg)
            2'h0: oe_n_next = 1'b0;
            2'h1: scl_next = 1'b1;
            2'h2: oe_n_next = 1'b1;
            default: begin
              done_next = 1'b1;
              ready_next = 1'b1;
              state_next = ee_link_pkg::H_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_reg <= ee_link_pkg::H_IDLE;
      seg_reg <= ee_link_pkg::SEG_SW;
      tick_reg <= 3'h0;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'hff;
      rx_reg <= 8'h0;
      scl_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      rd_reg <= 1'b0;
      rand_reg <= 1'b0;
      saddr_reg <= 7'h0;
      waddr_reg <= 8'h0;
      wdata_reg <= 8'h0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      ready_reg <= 1'b1;
      sda_sync_reg <= 2'h3;
    end else begin
      state_reg <= state_next;
      seg_reg <= seg_next;
      tick_reg <= tick_next;
      q_reg <= q_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      scl_reg <= scl_next;
      oe_n_reg <= oe_n_next;
      rd_reg <= rd_next;
      rand_reg <= rand_next;
      saddr_reg <= saddr_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      nack_reg <= nack_next;
      done_reg <= done_next;
      ready_reg <= ready_next;
      sda_sync_reg <= sda_sync_next;
    end
  end

  // link and user outputs from registers
  assign link.scl = scl_reg; // [RL18]
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe_n = oe_n_reg;
  assign o_cmd_ready = ready_reg;
  assign o_done = done_reg;
  assign o_nack = nack_reg;
  assign o_rdata = rx_reg;
endmodule : ee_master

// *** ee_link_assertions.sv ***
// assertions on the two-wire link between master and memory slave
// assumes the bench instantiates it beside the link, fed by name
`timescale 1ns/10ps
module ee_link_assertions #(
  parameter int WRITE_CYCLES = 200 // internal write length in clocks
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic o_busy,
  input wire logic o_standby
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [19:0] busy_len_reg; // clocks spent busy so far
  logic [19:0] busy_len_next;
  // count busy clocks, clear while not busy
  always_comb begin
    busy_len_next = o_busy ? busy_len_reg + 20'h1 : 20'h0;
  end
  // register the count
  always_ff @(posedge i_ref_clk) begin
    busy_len_reg <= i_rst_n ? busy_len_next : 20'h0;
  end
  chk_slave_open_drain: assert property (s_sda_o == 1'b0)
    else $error("slave data output not tied low");
  chk_data_clock_low: assert property ($changed(s_sda_oe_n) |-> !scl)
    else $error("slave moved data while clock high");
  chk_sync_latency: assert property ($changed(s_sda_oe_n) |-> !$past(scl, 2))
    else $error("slave reacted before clock was filtered");
  chk_busy_deaf: assert property (o_busy |-> s_sda_oe_n)
    else $error("slave drove the line while busy");
  chk_idle_quiet: assert property (o_standby |-> s_sda_oe_n)
    else $error("slave drove the line in standby");
  chk_busy_length: assert property ($fell(o_busy) |->
    busy_len_reg >= WRITE_CYCLES - 1 && busy_len_reg <= WRITE_CYCLES + 1)
    else $error("internal write length wrong");
  chk_busy_end_idle: assert property ($fell(o_busy) |-> o_standby)
    else $error("slave not in standby after write");
  chk_start_wakes: assert property (scl && $fell(sda) && !o_busy |-> ##[1:10] !o_standby)
    else $error("start not taken");
  chk_stop_ends: assert property (scl && $rose(sda) && !o_busy |->
    ##[1:10] (o_standby || o_busy))
    else $error("stop not taken");
  cover property ($rose(o_busy));
  cover property ($fell(s_sda_oe_n));
  cover property (scl && $rose(sda));
endmodule : ee_link_assertions

// *** tb_two_wire_eeprom_slave_interface.sv ***
// bench for both link ends; a second slave faces a bench-driven faulty master
// assumes the design files and the checker are compiled first
`timescale 1ns/10ps
module tb_two_wire_eeprom_slave_interface;
  localparam int WC = 2000; // shortened internal write
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cmd_valid = 1'b0, cmd_rd = 1'b0, cmd_rand = 1'b0;
  logic [6:0] sa = 7'h28;
  logic [7:0] wa = 8'h00, wd = 8'h00, rdata;
  logic cmd_ready, done, nack, busy, standby, busy2, standby2;
  logic [9:0] wire_sh = 10'h0; // last bits seen on the wire
  int n_errors = 0, n_compared = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  ee_two_wire_if link ();
  ee_two_wire_if link2 ();
  // record sda at each clock rise, msb first
  always @(posedge link.scl) wire_sh <= {wire_sh[8:0], link.sda};
  ee_master ee_master_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link.master),
    .i_cmd_valid(cmd_valid), .i_cmd_rd(cmd_rd), .i_cmd_rand(cmd_rand), .i_slave_addr(sa),
    .i_word_addr(wa), .i_wdata(wd), .o_cmd_ready(cmd_ready), .o_done(done), .o_nack(nack),
    .o_rdata(rdata));
  ee_slave #(.WRITE_CYCLES(WC)) ee_slave_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .link(link.slave), .o_busy(busy), .o_standby(standby));
  ee_slave #(.WRITE_CYCLES(WC)) ee_slave_i2 (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .link(link2.slave), .o_busy(busy2), .o_standby(standby2));
  ee_link_assertions #(.WRITE_CYCLES(WC)) ee_link_assertions_i (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .scl(link.scl), .sda(link.sda), .s_sda_o(link.s_sda_o),
    .s_sda_oe_n(link.s_sda_oe_n), .o_busy(busy), .o_standby(standby));
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // a used-up wait counts as a mismatch and ends the run
  task automatic limit(input int k, input int lim);
    if (k >= lim) begin
      n_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      close_out();
    end
  endtask : limit
  // one master command, waits for its done pulse
  task automatic cmd(input logic r, input logic q, input logic [6:0] a, input logic [7:0] w,
      input logic [7:0] d);
    int k;
    @(posedge i_ref_clk);
    cmd_valid <= 1'b1;
    cmd_rd <= r;
    cmd_rand <= q;
    sa <= a;
    wa <= w;
    wd <= d;
    @(posedge i_ref_clk);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge i_ref_clk);
      k++;
    end while (done !== 1'b1 && k < 5000);
    limit(k, 5000);
    // master accepts again in the cycle of its done pulse
    check(10'(cmd_ready), 10'h1);
  endtask : cmd
  task automatic busy_wait();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      @(negedge i_ref_clk);
      k++;
    end
    limit(k, 3000);
  endtask : busy_wait
  // byte writes, polling while busy, reserved bits set
  task automatic t_write();
    check(10'({link.scl, link.sda}), 10'h3);
    cmd(1'b0, 1'b0, 7'h2f, 8'hff, 8'h3c);
    check(10'(nack), 10'h0);
    check(wire_sh, {8'h3c, 2'b00});
    repeat (10) @(negedge i_ref_clk);
    check(10'(busy), 10'h1);
    cmd(1'b0, 1'b0, 7'h28, 8'h00, 8'ha5);
    check(10'(nack), 10'h1);
    busy_wait();
    check(10'(standby), 10'h1);
    cmd(1'b0, 1'b0, 7'h28, 8'h00, 8'ha5);
    check(10'(nack), 10'h0);
    busy_wait();
    $display("write test done");
  endtask : t_write
  // random read of the top byte, then current read wraps to zero
  task automatic t_read();
    cmd(1'b1, 1'b1, 7'h28, 8'hff, 8'h00);
    check({nack, 1'b0, rdata}, 10'h03c);
    check(wire_sh, {8'h3c, 2'b10});
    repeat (10) @(negedge i_ref_clk);
    check(10'(standby), 10'h1);
    cmd(1'b1, 1'b0, 7'h28, 8'h00, 8'h00);
    check({nack, 1'b0, rdata}, 10'h0a5);
    $display("read test done");
  endtask : t_read
  // wrong device type is never acknowledged and writes nothing
  task automatic t_other();
    cmd(1'b0, 1'b0, 7'h48, 8'h10, 8'h11);
    check(10'(nack), 10'h1);
    check(wire_sh, {8'h90, 2'b10});
    repeat (10) @(negedge i_ref_clk);
    check(10'(busy), 10'h0);
    $display("type test done");
  endtask : t_other
  // bench-made clock, 80 ns period, on the second link
  // data moves one clock after the clock line so it never races a falling scl
  task automatic bb(input logic c, input logic d);
    @(posedge i_ref_clk);
    link2.scl <= c;
    @(posedge i_ref_clk);
    link2.m_sda_oe_n <= d;
    repeat (2) @(posedge i_ref_clk);
  endtask : bb
  // start, four address bits, then a stop cutting the byte short
  task automatic t_abort();
    bb(1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      bb(1'b0, i[0] ? 1'b0 : 1'b1);
      bb(1'b1, i[0] ? 1'b0 : 1'b1);
    end
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    repeat (10) @(negedge i_ref_clk);
    check(10'({busy2, standby2, link2.s_sda_oe_n}), 10'h3);
    $display("abort test done");
  endtask : t_abort
  initial begin
    link2.scl = 1'b1;
    link2.m_sda_o = 1'b0;
    link2.m_sda_oe_n = 1'b1;
    repeat (16) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_write();
    t_read();
    t_other();
    t_abort();
    close_out();
  end
endmodule : tb_two_wire_eeprom_slave_interface
